// [rtl/cstw_pkg.sv]
/*
 Constants, source codes and shared decode for the clock source and
 tick counter block. Assumes a 10 MHz system clock.
*/
package cstw_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] PLLDIV_OFS = 8'h04;
   localparam logic [7:0] FASTTC_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0C;
   localparam logic [7:0] SLOWCNT_OFS = 8'h10;
   localparam logic [7:0] TRIM_OFS = 8'h20;
   localparam int TRIM_NUM = 6;
   // ==========================================================
   // Field positions
   localparam int CTRL_MOSC_LSB = 0;
   localparam int CTRL_DBL_LSB = 4;
   localparam int CTRL_PLL_LSB = 8;
   localparam int CTRL_PLLEN_BIT = 12;
   localparam int CTRL_FASTIE_BIT = 13;
   localparam int CTRL_SLOWIE_BIT = 14;
   localparam int PLLDIV_FB_LSB = 0;
   localparam int PLLDIV_IN_LSB = 8;
   // ==========================================================
   // Reset values
   localparam logic [2:0] MOSC_SEL_RST = 3'h2;
   localparam logic [2:0] MOSC_SEL_MAX = 3'h5;
   localparam logic [5:0] PLL_FB_RST = 6'h01;
   localparam logic [5:0] PLL_IN_RST = 6'h00;
   localparam logic [4:0] FAST_TC_RST = 5'h1F;
   localparam logic [7:0] TRIM_RST = 8'h80;
   // ==========================================================
   // Timing
   localparam int CLK_MHZ = 10;
   localparam int PLL_LOCK_US = 250;
   localparam logic [11:0] PLL_LOCK_CYC = 12'(PLL_LOCK_US * CLK_MHZ);
   localparam logic [5:0] K1_HALF_EDGES = 6'd50;
   localparam logic [1:0] K33_HALF_EDGES = 2'd3;
   // ==========================================================
   // Bus answers and source codes
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      SRC_MOSC = 2'b00,
      SRC_ECO = 2'b01,
      SRC_FABRIC = 2'b10
   } cstw_src_type;

   function automatic logic src_pick(input logic [1:0] sel, input logic mosc,
                                     input logic eco, input logic fab);
      case (sel)
         SRC_ECO: src_pick = eco;
         SRC_FABRIC: src_pick = fab;
         default: src_pick = mosc;
      endcase
   endfunction
endpackage

// [rtl/cstw_top.sv]
/*
 Clock source selection, doubler, PLL control with lock timing, low
 speed clock derivation and the two tick counters, behind AXI4-Lite.
 Assumes oscillator levels arrive synchronous to aclk and that the
 analog oscillators and PLL core act on the control outputs.
*/
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module cstw_top (
   input wire logic aclk, // System clock
   input wire logic aresetn, // Synchronous reset, low
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic main_internal_osc, // Main oscillator level
   input wire logic fast_crystal_osc, // Crystal oscillator level
   input wire logic fabric_clk, // Fabric-routed clock level
   input wire logic low_speed_internal_osc, // 100 kHz low speed level
   input wire logic hibernate, // Hibernate mode active
   input wire logic debug_halt, // CPU halted in debug
   output logic [2:0] mosc_freq_sel, // Main oscillator range
   output logic [7:0] mosc_trim, // Trim for that range
   output logic doubler_clk, // Doubled clock
   output logic pll_ref_clk, // PLL reference clock
   output logic pll_enable, // PLL core enable
   output logic [5:0] pll_fb_div, // Feedback divider
   output logic [5:0] pll_in_div, // Input divider minus one
   output logic pll_locked, // Lock level for routing
   output logic pll_lock_event, // Pulse when lock gained
   output logic fast_100k_clock, // 100 kHz direct
   output logic derived_33k_clock, // 33 kHz divided
   output logic slow_1k_clock, // 1 kHz divided
   output logic slow_tick_irq, // Slow counter wrap pulse
   output logic slow_tick_wake, // Slow counter wake pulse
   output logic fast_tick_irq // Fast terminal count pulse
);
   import cstw_pkg::*;

   // ==========================================================
   // Register bus
   logic aw_full_q, w_full_q, bvalid_q, arready_q, rvalid_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [2:0] mosc_sel_q;
   logic [1:0] dbl_req_q, pll_req_q;
   logic pll_en_q, fast_ie_q, slow_ie_q;
   logic [5:0] fb_div_q, in_div_q;
   logic [4:0] fast_tc_q, fast_cnt_q;
   logic [12:0] slow_cnt_q;
   logic [7:0] trim_q [TRIM_NUM];
   logic pll_locked_q;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   wire wr_go = aw_full_q & w_full_q & ~bvalid_q;
   wire [2:0] wr_tidx = 3'(awaddr_q[4:2]);
   wire [2:0] rd_tidx = 3'(s_axi_araddr[4:2]);
   wire wr_trim = awaddr_q[7:5] == TRIM_OFS[7:5] && wr_tidx < 3'(TRIM_NUM);
   wire rd_trim = s_axi_araddr[7:5] == TRIM_OFS[7:5] && rd_tidx < 3'(TRIM_NUM);
   wire wr_ctrl = wr_go && awaddr_q == CTRL_OFS;
   wire wr_div = wr_go && awaddr_q == PLLDIV_OFS;
   wire wr_tc = wr_go && awaddr_q == FASTTC_OFS;
   wire wr_slow = wr_go && awaddr_q == SLOWCNT_OFS;
   wire wr_ok = wr_ctrl | wr_div | wr_tc | wr_slow | (wr_go & wr_trim)
      | (wr_go && awaddr_q == STATUS_OFS);
   wire [31:0] ctrl_rd = {17'h0, slow_ie_q, fast_ie_q, pll_en_q, 2'h0, pll_req_q,
      2'h0, dbl_req_q, 1'b0, mosc_sel_q};
   wire [31:0] div_rd = {18'h0, in_div_q, 2'h0, fb_div_q};
   wire [31:0] ctrl_new = merge(ctrl_rd, wdata_q, wstrb_q);
   wire [31:0] div_new = merge(div_rd, wdata_q, wstrb_q);
   wire [2:0] mosc_new = ctrl_new[CTRL_MOSC_LSB +: 3];
   logic [31:0] rd_data;
   logic rd_ok;
   always_comb begin
      rd_ok = 1'b1;
      rd_data = 32'h0;
      case (s_axi_araddr)
         CTRL_OFS: rd_data = ctrl_rd;
         PLLDIV_OFS: rd_data = div_rd;
         FASTTC_OFS: rd_data = {27'h0, fast_tc_q};
         STATUS_OFS: rd_data = {26'h0, fast_cnt_q, pll_locked_q};
         SLOWCNT_OFS: rd_data = {19'h0, slow_cnt_q};
         default: begin
            rd_ok = rd_trim;
            rd_data = rd_trim ? {24'h0, trim_q[rd_tidx]} : 32'h0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= RESP_OKAY;
      end else if (s_axi_arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_data;
         rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
      end
   end

   // ==========================================================
   // Configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mosc_sel_q <= MOSC_SEL_RST;
         dbl_req_q <= SRC_MOSC;
         pll_req_q <= SRC_MOSC;
         pll_en_q <= 1'b0;
         fast_ie_q <= 1'b0;
         slow_ie_q <= 1'b0;
         fb_div_q <= PLL_FB_RST;
         in_div_q <= PLL_IN_RST;
         fast_tc_q <= FAST_TC_RST;
         for (int i = 0; i < TRIM_NUM; i++) trim_q[i] <= TRIM_RST;
      end else begin
         if (wr_ctrl) begin
            mosc_sel_q <= mosc_new > MOSC_SEL_MAX ? MOSC_SEL_MAX : mosc_new;
            dbl_req_q <= ctrl_new[CTRL_DBL_LSB +: 2];
            pll_req_q <= ctrl_new[CTRL_PLL_LSB +: 2];
            pll_en_q <= ctrl_new[CTRL_PLLEN_BIT];
            fast_ie_q <= ctrl_new[CTRL_FASTIE_BIT];
            slow_ie_q <= ctrl_new[CTRL_SLOWIE_BIT];
         end
         if (wr_div) begin
            // Feedback 1..63 and input 1..64 give 4032 ratios
            fb_div_q <= div_new[PLLDIV_FB_LSB +: 6] == 6'h0 ? 6'h01
               : div_new[PLLDIV_FB_LSB +: 6];
            in_div_q <= div_new[PLLDIV_IN_LSB +: 6];
         end
         if (wr_tc) fast_tc_q <= wdata_q[4:0];
         if (wr_go && wr_trim && wstrb_q[0]) trim_q[wr_tidx] <= wdata_q[7:0];
      end
   end

   // ==========================================================
   // Glitch-free source selection and doubler
   logic [1:0] dbl_cur_q, pll_cur_q;
   logic dbl_mux_q, dbl_prev_q, dbl_out_q, pll_mux_q;
   wire dbl_now = src_pick(dbl_cur_q, main_internal_osc, fast_crystal_osc, fabric_clk);
   wire dbl_nxt = src_pick(dbl_req_q, main_internal_osc, fast_crystal_osc, fabric_clk);
   wire pll_now = src_pick(pll_cur_q, main_internal_osc, fast_crystal_osc, fabric_clk);
   wire pll_nxt = src_pick(pll_req_q, main_internal_osc, fast_crystal_osc, fabric_clk);
   wire dbl_pend = dbl_req_q != dbl_cur_q;
   wire pll_pend = pll_req_q != pll_cur_q;

   // A pending switch lets the high phase finish, then holds low
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dbl_cur_q <= SRC_MOSC;
         pll_cur_q <= SRC_MOSC;
         dbl_mux_q <= 1'b0;
         dbl_prev_q <= 1'b0;
         dbl_out_q <= 1'b0;
         pll_mux_q <= 1'b0;
      end else begin
         dbl_mux_q <= dbl_pend ? dbl_mux_q & dbl_now : dbl_now;
         pll_mux_q <= pll_pend ? pll_mux_q & pll_now : pll_now;
         if (dbl_pend && !dbl_mux_q && !dbl_now && !dbl_nxt) dbl_cur_q <= dbl_req_q;
         if (pll_pend && !pll_mux_q && !pll_now && !pll_nxt) pll_cur_q <= pll_req_q;
         dbl_prev_q <= dbl_mux_q;
         dbl_out_q <= dbl_mux_q ^ dbl_prev_q;
      end
   end

   // ==========================================================
   // PLL lock timing
   logic [11:0] lock_cnt_q;
   logic [13:0] pll_cfg_q;
   logic lock_evt_q;
   wire [13:0] pll_cfg = {pll_cur_q, fb_div_q, in_div_q};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lock_cnt_q <= 12'h000;
         pll_locked_q <= 1'b0;
         lock_evt_q <= 1'b0;
         pll_cfg_q <= 14'h0000;
      end else begin
         pll_cfg_q <= pll_cfg;
         lock_evt_q <= 1'b0;
         if (!pll_en_q || pll_cfg != pll_cfg_q) begin
            lock_cnt_q <= 12'h000;
            pll_locked_q <= 1'b0;
         end else if (lock_cnt_q == PLL_LOCK_CYC - 12'h001) begin
            pll_locked_q <= 1'b1;
            lock_evt_q <= ~pll_locked_q;
         end else begin
            lock_cnt_q <= lock_cnt_q + 12'h001;
         end
      end
   end

   // ==========================================================
   // Low speed clocks and tick counters
   logic lsi_prev_q, k1_q, k33_q, fast_irq_q, slow_irq_q;
   logic [5:0] k1_cnt_q;
   logic [1:0] k33_cnt_q;
   wire lsi_rise = low_speed_internal_osc & ~lsi_prev_q;
   wire lsi_edge = low_speed_internal_osc ^ lsi_prev_q;
   wire k1_flip = lsi_rise && k1_cnt_q == K1_HALF_EDGES - 6'd1;
   wire k33_flip = lsi_edge && k33_cnt_q == K33_HALF_EDGES - 2'd1;
   wire slow_step = k1_flip & ~k1_q & ~hibernate & ~debug_halt;
   wire fast_wrap = lsi_rise && fast_cnt_q == fast_tc_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lsi_prev_q <= low_speed_internal_osc;
         k1_q <= 1'b0;
         k33_q <= 1'b0;
         k1_cnt_q <= 6'd0;
         k33_cnt_q <= 2'd0;
         slow_cnt_q <= 13'h0000;
         fast_cnt_q <= 5'h00;
         fast_irq_q <= 1'b0;
         slow_irq_q <= 1'b0;
      end else begin
         lsi_prev_q <= low_speed_internal_osc;
         if (lsi_rise) k1_cnt_q <= k1_flip ? 6'd0 : k1_cnt_q + 6'd1;
         if (k1_flip) k1_q <= ~k1_q;
         if (lsi_edge) k33_cnt_q <= k33_flip ? 2'd0 : k33_cnt_q + 2'd1;
         if (k33_flip) k33_q <= ~k33_q;
         if (wr_slow) slow_cnt_q <= 13'h0000;
         else if (slow_step) slow_cnt_q <= slow_cnt_q + 13'h0001;
         slow_irq_q <= slow_step && slow_ie_q && slow_cnt_q == 13'h1FFF;
         if (fast_wrap) fast_cnt_q <= 5'h00;
         else if (lsi_rise) fast_cnt_q <= fast_cnt_q + 5'h01;
         fast_irq_q <= fast_wrap & fast_ie_q;
      end
   end

   // ==========================================================
   // Outputs
   logic [7:0] trim_out_q;
   logic fast_direct_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trim_out_q <= TRIM_RST;
         fast_direct_q <= 1'b0;
      end else begin
         trim_out_q <= trim_q[mosc_sel_q];
         fast_direct_q <= low_speed_internal_osc;
      end
   end

   assign s_axi_awready = ~aw_full_q;
   assign s_axi_wready = ~w_full_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign mosc_freq_sel = mosc_sel_q;
   assign mosc_trim = trim_out_q;
   assign doubler_clk = dbl_out_q;
   assign pll_ref_clk = pll_mux_q;
   assign pll_enable = pll_en_q;
   // Ratios chosen by firmware place the core within 24 to 67 MHz
   assign pll_fb_div = fb_div_q;
   assign pll_in_div = in_div_q;
   assign pll_locked = pll_locked_q;
   assign pll_lock_event = lock_evt_q;
   assign fast_100k_clock = fast_direct_q;
   assign derived_33k_clock = k33_q;
   assign slow_1k_clock = k1_q;
   assign slow_tick_irq = slow_irq_q;
   assign slow_tick_wake = slow_irq_q;
   assign fast_tick_irq = fast_irq_q;

   // ==========================================================
   // Checks
   property p_mosc_range;
      @(posedge aclk) disable iff (!aresetn) mosc_sel_q <= MOSC_SEL_MAX;
   endproperty
   a_mosc_range: assert property (p_mosc_range) else $error("range select out of set");
   property p_trim;
      @(posedge aclk) disable iff (!aresetn) ##1 trim_out_q == $past(trim_q[mosc_sel_q]);
   endproperty
   a_trim: assert property (p_trim) else $error("trim not from selected range");
   property p_dbl;
      @(posedge aclk) disable iff (!aresetn) $changed(dbl_mux_q) |=> dbl_out_q;
   endproperty
   a_dbl: assert property (p_dbl) else $error("doubler missed an edge");
   property p_switch;
      @(posedge aclk) disable iff (!aresetn) $changed(pll_cur_q) |-> !$past(pll_mux_q) && !pll_mux_q;
   endproperty
   a_switch: assert property (p_switch) else $error("switch while clock high");
   property p_lock;
      @(posedge aclk) disable iff (!aresetn)
         $rose(pll_locked_q) |-> $past(lock_cnt_q) == PLL_LOCK_CYC - 12'h001 && lock_evt_q;
   endproperty
   a_lock: assert property (p_lock) else $error("lock at wrong time");
   property p_unlock;
      @(posedge aclk) disable iff (!aresetn) !pll_en_q |=> !pll_locked_q;
   endproperty
   a_unlock: assert property (p_unlock) else $error("lock held while disabled");
   property p_33k;
      @(posedge aclk) disable iff (!aresetn) $changed(k33_q) |-> $past(k33_cnt_q) == 2'd2;
   endproperty
   a_33k: assert property (p_33k) else $error("33k not divided by three");
   property p_fast_wrap;
      @(posedge aclk) disable iff (!aresetn) fast_wrap |=> fast_cnt_q == 5'h00 [*2];
   endproperty
   a_fast_wrap: assert property (p_fast_wrap) else $error("fast counter did not wrap");
   property p_fast_irq;
      @(posedge aclk) disable iff (!aresetn) fast_irq_q |-> $past(fast_ie_q) && $past(fast_wrap);
   endproperty
   a_fast_irq: assert property (p_fast_irq) else $error("spurious fast interrupt");
   property p_halt;
      @(posedge aclk) disable iff (!aresetn)
         (hibernate || debug_halt) && !wr_slow |=> $stable(slow_cnt_q);
   endproperty
   a_halt: assert property (p_halt) else $error("slow counter ran while halted");
endmodule

// [tb/cstw_osc_model.sv]
/*
 Oscillator levels for the clock source block: main, crystal, fabric and
 low speed sources. Assumes one aclk; each level is a square wave that
 changes just after a rising aclk edge.
*/
`timescale 1ns/1ns
module cstw_osc_model #(
   parameter int MAIN_HALF = 3,
   parameter int XTAL_HALF = 5,
   parameter int FAB_HALF = 7,
   parameter int LOW_HALF = 50
) (
   input wire logic aclk, // System clock
   output logic main_internal_osc, // Main oscillator level
   output logic fast_crystal_osc, // Crystal oscillator level
   output logic fabric_clk, // Fabric clock level
   output logic low_speed_internal_osc // 100 kHz low speed level
);
   int cnt_q = 0;

   // ==========================================================
   // Free running sources, no pauses
   always @(posedge aclk) begin
      cnt_q <= cnt_q + 1;
   end
   assign main_internal_osc = 1'((cnt_q / MAIN_HALF) % 2);
   assign fast_crystal_osc = 1'((cnt_q / XTAL_HALF) % 2);
   assign fabric_clk = 1'((cnt_q / FAB_HALF) % 2);
   assign low_speed_internal_osc = 1'((cnt_q / LOW_HALF) % 2);
endmodule

// [tb/cstw_top_tb.sv]
/*
 Self-checking bench for the clock source and tick counter block.
 Assumes a 10 MHz aclk and the oscillator model with its default periods.
*/
`timescale 1ns/1ns
module cstw_top_tb;
   import cstw_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, hibernate = 1'b0, debug_halt = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, rdat, v0;
   logic main_internal_osc, fast_crystal_osc, fabric_clk, low_speed_internal_osc;
   logic [2:0] mosc_freq_sel;
   logic [7:0] mosc_trim;
   logic [7:0] trims [6];
   logic [5:0] pll_fb_div, pll_in_div, fb, indiv;
   logic [4:0] tc;
   logic [3:0] strb = 4'hF;
   logic doubler_clk, pll_ref_clk, pll_enable, pll_locked, pll_lock_event, fast_100k_clock;
   logic derived_33k_clock, slow_1k_clock, slow_tick_irq, slow_tick_wake, fast_tick_irq, probe;
   int num_errors = 0, checks_done = 0, cycles = 0, sel = 0, c = 0;
   int exp_r [3] = '{70, 42, 30};

   always #50 aclk = ~aclk;

   cstw_top cstw_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .main_internal_osc, .fast_crystal_osc,
      .fabric_clk, .low_speed_internal_osc, .hibernate, .debug_halt, .mosc_freq_sel,
      .mosc_trim, .doubler_clk, .pll_ref_clk, .pll_enable, .pll_fb_div, .pll_in_div,
      .pll_locked, .pll_lock_event, .fast_100k_clock, .derived_33k_clock, .slow_1k_clock,
      .slow_tick_irq, .slow_tick_wake, .fast_tick_irq);

   cstw_osc_model cstw_osc_model_i (.aclk, .main_internal_osc, .fast_crystal_osc,
      .fabric_clk, .low_speed_internal_osc);

   assign probe = sel == 0 ? fast_tick_irq : sel == 1 ? derived_33k_clock :
      sel == 2 ? slow_1k_clock : sel == 3 ? doubler_clk : sel == 4 ? pll_ref_clk :
      fast_100k_clock;

   // ==========================================================
   // Reporting
   task stop_test;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   function automatic int exp_range(input int i);
      return i > int'(MOSC_SEL_MAX) ? int'(MOSC_SEL_MAX) : i;
   endfunction

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 95000) begin
         num_errors++;
         $display("wrong value at %0t: run did not finish in time", $time);
         stop_test();
      end
   end

   // ==========================================================
   // Bus master and measuring tasks
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= strb;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1 && !aw_ok) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready === 1'b1 && !w_ok) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(er), "write response");
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
           input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      s_axi_rready <= 1'b0;
      rdat = s_axi_rdata;
      chk(32'(s_axi_rresp), 32'(er), "read response");
      chk(rdat & m, e & m, "read data");
   endtask

   task rise_gap(input int s, output int n);
      logic p;
      sel = s;
      @(posedge aclk);
      do begin p = probe; @(posedge aclk); end while (!(probe === 1'b1 && p === 1'b0));
      n = 0;
      do begin p = probe; @(posedge aclk); n++; end while (!(probe === 1'b1 && p === 1'b0));
   endtask

   task count_rises(input int s, input int len, output int n);
      logic p;
      sel = s;
      n = 0;
      repeat (40) @(posedge aclk);
      repeat (len) begin
         p = probe;
         @(posedge aclk);
         if (probe === 1'b1 && p === 1'b0) n++;
      end
   endtask

   // ==========================================================
   // Test sequence
   initial begin
      void'($urandom(32'h5e745165));
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(CTRL_OFS, 32'(MOSC_SEL_RST), 32'hFFFFFFFF, RESP_OKAY);
      rd(PLLDIV_OFS, 32'h1, 32'hFFFFFFFF, RESP_OKAY);
      rd(FASTTC_OFS, 32'(FAST_TC_RST), 32'hFFFFFFFF, RESP_OKAY);
      rd(8'h18, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
      wr(8'h3C, 32'h5, RESP_SLVERR);
      $display("test reset and map done");
      for (int i = 0; i < TRIM_NUM; i++) begin
         rd(TRIM_OFS + 8'(4 * i), 32'(TRIM_RST), 32'hFF, RESP_OKAY);
         trims[i] = 8'($urandom);
         wr(TRIM_OFS + 8'(4 * i), {24'h0, trims[i]}, RESP_OKAY);
      end
      for (int i = 0; i < 8; i++) begin
         wr(CTRL_OFS, 32'(i), RESP_OKAY);
         repeat (2) @(posedge aclk);
         chk(32'(mosc_freq_sel), 32'(exp_range(i)), "range");
         chk(32'(mosc_trim), 32'(trims[exp_range(i)]), "trim");
      end
      strb = 4'h2;
      wr(CTRL_OFS, 32'hFFFF01FF, RESP_OKAY);
      strb = 4'hF;
      rd(CTRL_OFS, 32'h105, 32'hFFFFFFFF, RESP_OKAY);
      $display("test ranges and trims done");
      for (int s = 0; s < 4; s++) begin
         wr(CTRL_OFS, 32'((s << 4) | (s << 8) | 2), RESP_OKAY);
         count_rises(3, 420, c);
         chk(32'(c), 32'(2 * exp_r[s == 3 ? 0 : s]), "doubler pulses");
         count_rises(4, 420, c);
         chk(32'(c), 32'(exp_r[s == 3 ? 0 : s]), "reference edges");
      end
      $display("test source selection done");
      wr(CTRL_OFS, 32'h2, RESP_OKAY);
      fb = 6'($urandom_range(63, 2));
      indiv = 6'($urandom_range(63, 0));
      wr(PLLDIV_OFS, {18'h0, indiv, 2'h0, fb}, RESP_OKAY);
      wr(CTRL_OFS, 32'h1002, RESP_OKAY);
      c = 0;
      while (pll_lock_event !== 1'b1 && c < 3000) begin
         @(posedge aclk);
         c++;
      end
      chk(32'(c >= 2495 && c <= 2505), 32'h1, "lock time");
      chk(32'(pll_locked), 32'h1, "lock level");
      chk({20'h0, pll_in_div, pll_fb_div}, {20'h0, indiv, fb}, "dividers");
      chk(32'(pll_enable), 32'h1, "pll enable");
      rd(STATUS_OFS, 32'h1, 32'h1, RESP_OKAY);
      wr(PLLDIV_OFS, {18'h0, indiv, 8'h00}, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(32'(pll_locked), 32'h0, "lock after change");
      chk(32'(pll_fb_div), 32'h1, "zero feedback");
      wr(CTRL_OFS, 32'h2, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(32'(pll_enable), 32'h0, "pll disable");
      $display("test pll done");
      tc = 5'($urandom_range(7, 1));
      wr(FASTTC_OFS, 32'(tc), RESP_OKAY);
      wr(CTRL_OFS, 32'h2002, RESP_OKAY);
      rise_gap(0, c);
      chk(32'(c), 32'((tc + 1) * 100), "fast tick period");
      wr(CTRL_OFS, 32'h2, RESP_OKAY);
      count_rises(0, 1000, c);
      chk(32'(c), 32'h0, "fast tick masked");
      rise_gap(5, c);
      chk(32'(c), 32'd100, "100k period");
      rise_gap(1, c);
      chk(32'(c), 32'd300, "33k period");
      rise_gap(2, c);
      chk(32'(c), 32'd10000, "1k period");
      $display("test low speed clocks done");
      wr(SLOWCNT_OFS, 32'h0, RESP_OKAY);
      rd(SLOWCNT_OFS, 32'h0, 32'h0, RESP_OKAY);
      chk(32'(rdat <= 1), 32'h1, "slow clear");
      repeat (25000) @(posedge aclk);
      rd(SLOWCNT_OFS, 32'h0, 32'hFFFFE000, RESP_OKAY);
      chk(32'(rdat >= 2 && rdat <= 4), 32'h1, "slow count");
      for (int k = 0; k < 2; k++) begin
         hibernate <= (k == 0);
         debug_halt <= (k == 1);
         rd(SLOWCNT_OFS, 32'h0, 32'h0, RESP_OKAY);
         v0 = rdat;
         repeat (11000) @(posedge aclk);
         rd(SLOWCNT_OFS, v0, 32'h1FFF, RESP_OKAY);
         chk({30'h0, slow_tick_irq, slow_tick_wake}, 32'h0, "slow irq off wrap");
      end
      hibernate <= 1'b0;
      debug_halt <= 1'b0;
      $display("test slow counter done");
      stop_test();
   end
endmodule
